// [design/mies_pkg.sv]
// Operation
// [RULE1] byte set writes all ones, flags kept
// [RULE2] bit set forces chosen bit, flags kept
// [RULE3] increment stores back, skips when zero
// [RULE4] increment into accumulator, skips when zero
// [RULE5] every taken skip costs two cycles
// [RULE6] skip when chosen bit is one
// [RULE7] register subtract into accumulator, four flags
// [RULE8] carry is inverted borrow on subtraction
// [RULE9] difference stored to memory, four flags
// [RULE10] immediate subtract into accumulator, four flags
// [RULE11] nibble swap in place, flags kept
// [RULE12] swapped byte into accumulator, memory kept
// [RULE13] rewrite byte, skip when zero
// [RULE14] copy byte to accumulator, skip when zero
// [RULE15] skip when chosen bit is zero
// [RULE16] paged table fetch splits program word
// [RULE17] last page table fetch splits word
// [RULE18] register xor into accumulator, zero flag
// [RULE19] xor written back to memory, zero flag
// [RULE20] immediate xor into accumulator
package mies_pkg;
  // ------------------------------------------------------------
  // sizes
  // ------------------------------------------------------------
  localparam int         DM_DEPTH   = 64;    // data memory bytes
  localparam int         DM_AW      = 6;     // data memory address bits
  localparam int         PM_AW      = 11;    // program word address bits
  localparam int         PM_DW      = 16;    // program word width
  localparam int         LO_PTR_W   = 8;     // low table pointer width
  localparam int         HI_PTR_W   = 3;     // high table pointer width
  localparam logic       HAS_HI_PTR = 1'h1;  // high pointer present
  localparam logic [2:0] LAST_PAGE  = 3'h7;  // top program page
  localparam logic [7:0] BYTE_ONES  = 8'hff; // byte set pattern
  localparam logic [7:0] BYTE_ONE   = 8'h01; // increment step
  // ------------------------------------------------------------
  // register offsets (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_CMD    = 8'h00; // command, write starts
  localparam logic [7:0] OFS_STATUS = 8'h04; // busy, skip, cycles
  localparam logic [7:0] OFS_FLAGS  = 8'h08; // carry, half, zero, range
  localparam logic [7:0] OFS_ACC    = 8'h0c; // accumulator
  localparam logic [7:0] OFS_TIL    = 8'h10; // table_index_low
  localparam logic [7:0] OFS_TIH    = 8'h14; // table_index_high
  localparam logic [7:0] OFS_TUB    = 8'h18; // table_upper_byte_reg
  localparam logic [7:0] OFS_MADDR  = 8'h1c; // memory window address
  localparam logic [7:0] OFS_MDATA  = 8'h20; // memory window data
  // ------------------------------------------------------------
  // command fields
  // ------------------------------------------------------------
  localparam int CMD_OP_LSB  = 0;  // 5-bit opcode
  localparam int CMD_BIT_LSB = 5;  // 3-bit bit select
  localparam int CMD_ADR_LSB = 8;  // 6-bit data address
  localparam int CMD_IMM_LSB = 16; // 8-bit immediate
  // ------------------------------------------------------------
  // reset values, responses, cycle counts
  // ------------------------------------------------------------
  localparam logic [7:0] ACC_RST     = 8'h00;
  localparam logic [3:0] FLAGS_RST   = 4'h0;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] CYC_PLAIN   = 2'h1; // one-cycle instruction
  localparam logic [1:0] CYC_SKIP    = 2'h2; // skip or table fetch

  typedef enum logic [4:0] {
    OP_SET_BYTE, OP_SET_BIT, OP_INC_TEST_SKIP_STORE,
    OP_INC_TEST_SKIP_TO_ACC, OP_BIT_SET_SKIP, OP_SUB_REG,
    OP_DIFFERENCE_TO_MEMORY, OP_SUB_IMM, OP_SWAP_MEM,
    OP_NIBBLE_EXCHANGE_TO_ACC, OP_NULL_TEST_SKIP,
    OP_NULL_TEST_COPY_SKIP, OP_BIT_CLR_SKIP, OP_TABLE_FETCH_PAGED,
    OP_TABLE_FETCH_FINAL_PAGE, OP_XOR_REG,
    OP_EXCLUSIVE_OR_TO_MEMORY, OP_XOR_IMM
  } mies_op_e;

  typedef enum logic [2:0] {
    S_IDLE, S_EXEC, S_DUMMY, S_TAB_WAIT, S_TAB_DONE
  } mies_state_e;

  typedef struct packed {
    logic srf; // signed_range_fault
    logic z;
    logic hbc; // half_byte_carry
    logic c;
  } mies_flags_s;

  // what one executed instruction changes
  typedef struct packed {
    logic        acc_we;
    logic [7:0]  acc_val;
    logic        mem_we;
    logic [7:0]  mem_val;
    mies_flags_s flags;
    logic        skip;
  } mies_alu_s;
endpackage : mies_pkg

// [design/mies_alu.sv]
`timescale 1ns/10ps
`default_nettype none
module mies_alu
  import mies_pkg::*;
(
  input  wire mies_op_e    op,
  input  wire logic [7:0]  acc,
  input  wire logic [7:0]  opnd,
  input  wire logic [2:0]  bitsel,
  input  wire logic [7:0]  imm,
  input  wire mies_flags_s flags_in,
  output mies_alu_s        res
);
  // ------------------------------------------------------------
  // datapath for one instruction, purely combinational
  // ------------------------------------------------------------
  always_comb begin
    logic [8:0] diff;   // nine bits keep the borrow
    logic [4:0] ldiff;  // low nibble borrow
    logic [7:0] sub_b;  // subtrahend
    logic [7:0] inc;    // operand plus one
    logic [7:0] xr;     // xor source result
    logic [7:0] sw;     // nibble-swapped operand
    mies_flags_s sf;    // subtraction flags
    sub_b = (op == OP_SUB_IMM) ? imm : opnd;
    diff  = {1'b0, acc} - {1'b0, sub_b};
    ldiff = {1'b0, acc[3:0]} - {1'b0, sub_b[3:0]};
    inc   = opnd + BYTE_ONE;
    xr    = acc ^ ((op == OP_XOR_IMM) ? imm : opnd);
    sw    = {opnd[3:0], opnd[7:4]};
    // carry and half carry are inverted borrows
    sf.c  = ~diff[8];                              // RULE8
    sf.hbc = ~ldiff[4];
    sf.z   = (diff[7:0] == 8'h00);
    sf.srf = (acc[7] ^ sub_b[7]) & (diff[7] ^ acc[7]);
    res         = '0;
    res.acc_val = acc;
    res.mem_val = opnd;
    res.flags   = flags_in;
    case (op)
      OP_SET_BYTE: begin
        res.mem_we  = 1'b1;                        // RULE1
        res.mem_val = BYTE_ONES;
      end
      OP_SET_BIT: begin
        res.mem_we          = 1'b1;                // RULE2
        res.mem_val[bitsel] = 1'b1;
      end
      OP_INC_TEST_SKIP_STORE: begin
        res.mem_we  = 1'b1;                        // RULE3
        res.mem_val = inc;
        res.skip    = (inc == 8'h00);
      end
      OP_INC_TEST_SKIP_TO_ACC: begin
        res.acc_we  = 1'b1;                        // RULE4
        res.acc_val = inc;
        res.skip    = (inc == 8'h00);
      end
      OP_BIT_SET_SKIP: res.skip = opnd[bitsel];   // RULE6
      OP_BIT_CLR_SKIP: res.skip = ~opnd[bitsel];  // RULE15
      OP_SUB_REG, OP_SUB_IMM: begin
        res.acc_we  = 1'b1;                        // RULE7 RULE10
        res.acc_val = diff[7:0];
        res.flags   = sf;
      end
      OP_DIFFERENCE_TO_MEMORY: begin
        res.mem_we  = 1'b1;                        // RULE9
        res.mem_val = diff[7:0];
        res.flags   = sf;
      end
      OP_SWAP_MEM: begin
        res.mem_we  = 1'b1;                        // RULE11
        res.mem_val = sw;
      end
      OP_NIBBLE_EXCHANGE_TO_ACC: begin
        res.acc_we  = 1'b1;                        // RULE12
        res.acc_val = sw;
      end
      OP_NULL_TEST_SKIP: begin
        res.mem_we = 1'b1;                         // RULE13
        res.skip   = (opnd == 8'h00);
      end
      OP_NULL_TEST_COPY_SKIP: begin
        res.acc_we  = 1'b1;                        // RULE14
        res.acc_val = opnd;
        res.skip    = (opnd == 8'h00);
      end
      OP_XOR_REG, OP_XOR_IMM: begin
        res.acc_we  = 1'b1;                        // RULE18 RULE20
        res.acc_val = xr;
        res.flags.z = (xr == 8'h00);
      end
      OP_EXCLUSIVE_OR_TO_MEMORY: begin
        res.mem_we  = 1'b1;                        // RULE19
        res.mem_val = xr;
        res.flags.z = (xr == 8'h00);
      end
      // table fetches and unused codes change nothing here
      default: res.skip = 1'b0;
    endcase
  end
endmodule : mies_alu
`default_nettype wire

// [design/mies_core.sv]
// Implementation choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module mies_core
  import mies_pkg::*;
(
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [31:0]      awaddr,
  input  wire logic             awvalid,
  output logic                  awready,
  input  wire logic [31:0]      wdata,
  input  wire logic [3:0]       wstrb,
  input  wire logic             wvalid,
  output logic                  wready,
  output logic [1:0]            bresp,
  output logic                  bvalid,
  input  wire logic             bready,
  input  wire logic [31:0]      araddr,
  input  wire logic             arvalid,
  output logic                  arready,
  output logic [31:0]           rdata,
  output logic [1:0]            rresp,
  output logic                  rvalid,
  input  wire logic             rready,
  output logic [PM_AW-1:0]      prog_addr,
  output logic                  prog_re,
  input  wire logic [PM_DW-1:0] prog_rdata,
  output logic                  skip_next,
  output logic                  busy
);
  // ------------------------------------------------------------
  // module state, one packed struct
  // ------------------------------------------------------------
  typedef struct packed {
    mies_state_e               state;     // sequencer
    logic                      aw_held;   // write address captured
    logic [7:0]                aw_addr;
    logic                      w_held;    // write data captured
    logic [31:0]               w_data;
    logic [3:0]                w_strb;
    logic                      bvalid;
    logic [1:0]                bresp;
    logic                      rvalid;
    logic [31:0]               rdata;
    logic [1:0]                rresp;
    mies_op_e                  op;        // current instruction
    logic [2:0]                bitsel;
    logic [DM_AW-1:0]          addr;
    logic [7:0]                imm;
    logic [7:0]                acc;
    mies_flags_s               flags;
    logic [LO_PTR_W-1:0]       til;       // table_index_low
    logic [HI_PTR_W-1:0]       tih;       // table_index_high
    logic [7:0]                tub;       // table_upper_byte_reg
    logic [DM_AW-1:0]          maddr;     // memory window pointer
    logic [DM_DEPTH-1:0][7:0]  mem;       // data memory
    logic                      skip;      // last instruction skipped
    logic [1:0]                cyc;       // cycles of last instr
    logic [PM_AW-1:0]          prog_addr;
    logic                      prog_re;
    logic                      skip_pls;
  } mies_st_s;

  mies_st_s   st_r;     // registered state
  mies_st_s   st_nxt;   // next state
  mies_alu_s  alu_res;  // datapath answer
  logic [7:0] opnd;     // addressed data byte
  logic [7:0] swapped;  // operand with halves exchanged
  logic       opnd_bit; // selected bit of operand
  logic       wr_go;    // register write performed this cycle
  logic [31:0] rmux;    // read data for the offered address

  assign opnd     = st_r.mem[st_r.addr];
  assign swapped  = {opnd[3:0], opnd[7:4]};
  assign opnd_bit = opnd[st_r.bitsel];

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // a write is held off while a command runs, so a new command
  // can never overtake the one in flight
  assign awready   = ~st_r.aw_held;
  assign wready    = ~st_r.w_held;
  assign bvalid    = st_r.bvalid;
  assign bresp     = st_r.bresp;
  assign arready   = ~st_r.rvalid;
  assign rvalid    = st_r.rvalid;
  assign rdata     = st_r.rdata;
  assign rresp     = st_r.rresp;
  assign prog_addr = st_r.prog_addr;
  assign prog_re   = st_r.prog_re;
  assign skip_next = st_r.skip_pls;
  assign busy      = (st_r.state != S_IDLE);
  assign wr_go     = st_r.aw_held & st_r.w_held & ~st_r.bvalid
                   & (st_r.state == S_IDLE);

  mies_alu u_alu (
    .op       (st_r.op),
    .acc      (st_r.acc),
    .opnd     (opnd),
    .bitsel   (st_r.bitsel),
    .imm      (st_r.imm),
    .flags_in (st_r.flags),
    .res      (alu_res)
  );

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  always_comb begin
    rmux = '0;
    case (araddr[7:0])
      OFS_CMD: begin
        rmux[CMD_OP_LSB +: 5]      = st_r.op;
        rmux[CMD_BIT_LSB +: 3]     = st_r.bitsel;
        rmux[CMD_ADR_LSB +: DM_AW] = st_r.addr;
        rmux[CMD_IMM_LSB +: 8]     = st_r.imm;
      end
      OFS_STATUS: rmux[3:0] = {st_r.cyc, st_r.skip, busy};
      OFS_FLAGS:  rmux[3:0] = st_r.flags;
      OFS_ACC:    rmux[7:0] = st_r.acc;
      OFS_TIL:    rmux[LO_PTR_W-1:0] = st_r.til;
      OFS_TIH:    rmux[HI_PTR_W-1:0] = st_r.tih;
      OFS_TUB:    rmux[7:0] = st_r.tub;
      OFS_MADDR:  rmux[DM_AW-1:0] = st_r.maddr;
      OFS_MDATA:  rmux[7:0] = st_r.mem[st_r.maddr];
      default:    rmux = '0; // unmapped reads zero
    endcase
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    st_nxt          = st_r;
    st_nxt.prog_re  = 1'b0;
    st_nxt.skip_pls = 1'b0;
    // write channels captured independently, in either order
    if (awvalid && !st_r.aw_held) begin
      st_nxt.aw_held = 1'b1;
      st_nxt.aw_addr = awaddr[7:0];
    end
    if (wvalid && !st_r.w_held) begin
      st_nxt.w_held = 1'b1;
      st_nxt.w_data = wdata;
      st_nxt.w_strb = wstrb;
    end
    if (st_r.bvalid && bready) begin
      st_nxt.bvalid = 1'b0;
    end
    // read: answer one cycle after the address is taken
    if (arvalid && !st_r.rvalid) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata  = rmux;
      st_nxt.rresp  = RESP_OKAY;
      case (araddr[7:0])
        OFS_CMD, OFS_STATUS, OFS_FLAGS, OFS_ACC, OFS_TIL,
        OFS_TIH, OFS_TUB, OFS_MADDR, OFS_MDATA: ;
        default: st_nxt.rresp = RESP_SLVERR;
      endcase
    end else if (st_r.rvalid && rready) begin
      st_nxt.rvalid = 1'b0;
    end
    // register write, only while no instruction runs
    if (wr_go) begin
      st_nxt.aw_held = 1'b0;
      st_nxt.w_held  = 1'b0;
      st_nxt.bvalid  = 1'b1;
      st_nxt.bresp   = RESP_OKAY;
      case (st_r.aw_addr)
        OFS_CMD: if (st_r.w_strb[0]) begin
          // decode and launch an instruction
          st_nxt.op     = mies_op_e'(st_r.w_data[CMD_OP_LSB +: 5]);
          st_nxt.bitsel = st_r.w_data[CMD_BIT_LSB +: 3];
          st_nxt.addr   = st_r.w_data[CMD_ADR_LSB +: DM_AW];
          st_nxt.imm    = st_r.w_data[CMD_IMM_LSB +: 8];
          st_nxt.state  = S_EXEC;
          if (st_nxt.op == OP_TABLE_FETCH_PAGED) begin
            st_nxt.state     = S_TAB_WAIT;
            st_nxt.prog_re   = 1'b1;
            // without a high pointer the low one alone addresses
            st_nxt.prog_addr = HAS_HI_PTR ? {st_r.tih, st_r.til}
                             : {{HI_PTR_W{1'b0}}, st_r.til}; // RULE16
          end else if (st_nxt.op == OP_TABLE_FETCH_FINAL_PAGE) begin
            st_nxt.state     = S_TAB_WAIT;
            st_nxt.prog_re   = 1'b1;
            st_nxt.prog_addr = {LAST_PAGE, st_r.til}; // RULE17
          end
        end
        OFS_STATUS, OFS_TUB: ; // read only, write ignored
        OFS_FLAGS:
          if (st_r.w_strb[0]) st_nxt.flags = st_r.w_data[3:0];
        OFS_ACC:
          if (st_r.w_strb[0]) st_nxt.acc = st_r.w_data[7:0];
        OFS_TIL:
          if (st_r.w_strb[0]) st_nxt.til = st_r.w_data[LO_PTR_W-1:0];
        OFS_TIH:
          if (st_r.w_strb[0]) st_nxt.tih = st_r.w_data[HI_PTR_W-1:0];
        OFS_MADDR:
          if (st_r.w_strb[0]) st_nxt.maddr = st_r.w_data[DM_AW-1:0];
        OFS_MDATA:
          if (st_r.w_strb[0]) st_nxt.mem[st_r.maddr] = st_r.w_data[7:0];
        default: st_nxt.bresp = RESP_SLVERR; // unmapped
      endcase
    end
    // instruction sequencer
    case (st_r.state)
      S_IDLE: ;
      S_EXEC: begin
        if (alu_res.acc_we) st_nxt.acc = alu_res.acc_val;
        if (alu_res.mem_we) st_nxt.mem[st_r.addr] = alu_res.mem_val;
        st_nxt.flags    = alu_res.flags;
        st_nxt.skip     = alu_res.skip;
        st_nxt.skip_pls = alu_res.skip;
        // a skip inserts a dummy cycle, so it counts as two
        st_nxt.state = alu_res.skip ? S_DUMMY : S_IDLE;   // RULE5
        st_nxt.cyc   = alu_res.skip ? CYC_SKIP : CYC_PLAIN;
      end
      S_DUMMY: st_nxt.state = S_IDLE;
      // program memory answers one cycle after the read strobe
      S_TAB_WAIT: st_nxt.state = S_TAB_DONE;
      S_TAB_DONE: begin
        st_nxt.mem[st_r.addr] = prog_rdata[7:0];     // RULE16 RULE17
        st_nxt.tub   = prog_rdata[15:8];
        st_nxt.skip  = 1'b0;
        st_nxt.cyc   = CYC_SKIP;
        st_nxt.state = S_IDLE;
      end
      default: st_nxt.state = S_IDLE;
    endcase
  end

  // ------------------------------------------------------------
  // state register, synchronous reset
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r       <= '0;
      st_r.state <= S_IDLE;
      st_r.acc   <= ACC_RST;
      st_r.flags <= FLAGS_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic ex; // an instruction executes this cycle
  assign ex = (st_r.state == S_EXEC);

  a_set_byte_ones: assert property ( // RULE1
    ex && st_r.op == OP_SET_BYTE |=>
      st_r.mem[$past(st_r.addr)] == BYTE_ONES
      && st_r.flags == $past(st_r.flags))
    else $error("byte set did not leave all ones");

  a_set_bit_one: assert property ( // RULE2
    ex && st_r.op == OP_SET_BIT |=>
      st_r.mem[$past(st_r.addr)][$past(st_r.bitsel)]
      && st_r.flags == $past(st_r.flags))
    else $error("bit set did not force the bit");

  a_inc_store_skip: assert property ( // RULE3
    ex && st_r.op == OP_INC_TEST_SKIP_STORE |=>
      st_r.mem[$past(st_r.addr)] == 8'($past(opnd) + BYTE_ONE)
      && skip_next == (st_r.mem[$past(st_r.addr)] == 8'h00))
    else $error("increment store or its skip is wrong");

  a_inc_acc_skip: assert property ( // RULE4
    ex && st_r.op == OP_INC_TEST_SKIP_TO_ACC |=>
      st_r.acc == 8'($past(opnd) + BYTE_ONE)
      && skip_next == (st_r.acc == 8'h00)
      && st_r.mem[$past(st_r.addr)] == $past(opnd))
    else $error("increment to accumulator is wrong");

  a_skip_two_cyc: assert property ( // RULE5
    skip_next |-> st_r.state == S_DUMMY && st_r.cyc == CYC_SKIP
      ##1 st_r.state == S_IDLE)
    else $error("skip did not take two cycles");

  a_bit_skip_test: assert property ( // RULE6
    ex && st_r.op == OP_BIT_SET_SKIP |=> skip_next == $past(opnd_bit))
    else $error("bit set skip decision is wrong");

  a_sub_inv_borrow: assert property ( // RULE8
    ex && (st_r.op == OP_SUB_REG || st_r.op == OP_DIFFERENCE_TO_MEMORY)
      |=> st_r.flags.c == ($past(st_r.acc) >= $past(opnd)))
    else $error("carry is not the inverted borrow");

  a_sub_reg_acc: assert property ( // RULE7
    ex && st_r.op == OP_SUB_REG |=>
      st_r.acc == 8'($past(st_r.acc) - $past(opnd))
      && st_r.flags.z == (st_r.acc == 8'h00))
    else $error("register subtract result is wrong");

  a_swap_in_place: assert property ( // RULE11
    ex && st_r.op == OP_SWAP_MEM |=>
      st_r.mem[$past(st_r.addr)] == $past(swapped)
      && st_r.flags == $past(st_r.flags))
    else $error("nibble swap in place is wrong");

  a_table_split: assert property ( // RULE16
    st_r.state == S_TAB_DONE |=>
      {st_r.tub, st_r.mem[$past(st_r.addr)]} == $past(prog_rdata))
    else $error("table word not split into upper and memory");

  a_last_page_addr: assert property ( // RULE17
    prog_re && st_r.op == OP_TABLE_FETCH_FINAL_PAGE |->
      prog_addr == {LAST_PAGE, st_r.til} ##2 st_r.state == S_IDLE)
    else $error("last page fetch used a wrong address");

  a_xor_zero_only: assert property ( // RULE18
    ex && st_r.op == OP_XOR_REG |=>
      st_r.acc == ($past(st_r.acc) ^ $past(opnd))
      && st_r.flags.z == (st_r.acc == 8'h00)
      && st_r.flags.c == $past(st_r.flags.c))
    else $error("register xor result or flags wrong");

  c_skip_taken: cover property (ex && alu_res.skip ##1 skip_next);
  c_table_paged: cover property (
    prog_re && st_r.op == OP_TABLE_FETCH_PAGED ##2 st_r.state == S_IDLE);
  c_sub_negative: cover property (
    ex && st_r.op == OP_SUB_IMM ##1 !st_r.flags.c);
endmodule : mies_core
`default_nettype wire

// [verification/mies_prog_model.sv]
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// program memory seen by the table fetch
// ------------------------------------------------------------
module mies_prog_model (
  input  wire logic        aclk,
  input  wire logic [10:0] prog_addr,
  input  wire logic        prog_re,
  output var  logic [15:0] prog_rdata
);
  logic [15:0] word_r = 16'h0000; // held program word
  // word valid one cycle after the strobe, inverted each cycle after that so
  // a sample an odd number of cycles late sees the complement of the word
  always @(posedge aclk) begin
    if (prog_re) begin
      word_r <= {5'h15, prog_addr};
    end else begin
      word_r <= ~word_r;
    end
  end
  assign prog_rdata = word_r;
endmodule : mies_prog_model
`default_nettype wire

// [verification/tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import mies_pkg::*;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, prog_re, skip_next;
  logic        busy;
  logic [31:0] awaddr, wdata, araddr, rdata, rd_d;
  logic [1:0]  bresp, rresp, rd_r, wr_r;
  logic [10:0] prog_addr;
  logic [15:0] prog_rdata;
  logic [28:0] ex;             // {skip, upper byte, flags, mem, acc}
  logic [7:0]  a, m, i, lo, tb;
  logic [5:0]  adr;
  logic [4:0]  op;
  logic [3:0]  f, ws;
  logic [2:0]  b, hi;
  int          failures, cmp_count, sk_cnt, n;
  mies_core i_mies_core (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(ws),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .prog_addr(prog_addr), .prog_re(prog_re), .prog_rdata(prog_rdata),
    .skip_next(skip_next), .busy(busy));
  mies_prog_model i_mies_prog_model (.aclk(aclk), .prog_addr(prog_addr),
    .prog_re(prog_re), .prog_rdata(prog_rdata));
  // ------------------------------------------------------------
  // clock, skip pulse counter, watchdog
  // ------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  always @(posedge aclk) if (skip_next === 1'b1) sk_cnt++;
  initial begin
    #1_500_000;
    failures++;
    give_verdict();
  end
  // ------------------------------------------------------------
  // checking and bus tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // first edge keeps a release and the next request apart
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge aclk);
    awaddr <= {24'h0, ad}; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      k++;
    end while (bvalid !== 1'b1 && k < 200);
    if (k >= 200) failures++;
    wr_r = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] ad);
    int k;
    k = 0;
    @(posedge aclk);
    araddr <= {24'h0, ad}; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      k++;
    end while (rvalid !== 1'b1 && k < 200);
    if (k >= 200) failures++;
    rd_d = rdata; rd_r = rresp;
    rready <= 1'b0;
  endtask : rd
  // expected effect of one instruction, worked out independently
  function automatic logic [28:0] expect_of(input logic [4:0] o,
      input logic [7:0] a, m, i, lo, t, input logic [2:0] b, hi,
      input logic [3:0] f);
    logic [7:0] s, r;
    logic k;
    logic [15:0] w;
    s = (o == 5'd7) ? i : m;
    r = a - s;
    k = 1'b0;
    case (o)
      5'd0: m = 8'hff;
      5'd1: m[b] = 1'b1;
      5'd2: begin m = m + 8'h01; k = (m == 8'h00); end
      5'd3: begin a = m + 8'h01; k = (a == 8'h00); end
      5'd4: k = m[b];
      5'd5, 5'd6, 5'd7: begin
        f = {(a[7] ^ s[7]) & (a[7] ^ r[7]), r == 8'h00,
             a[3:0] >= s[3:0], a >= s};
        if (o == 5'd6) m = r; else a = r;
      end
      5'd8: m = {m[3:0], m[7:4]};
      5'd9: a = {m[3:0], m[7:4]};
      5'd10: k = (m == 8'h00);
      5'd11: begin a = m; k = (m == 8'h00); end
      5'd12: k = ~m[b];
      5'd13, 5'd14: begin
        w = {5'h15, (o == 5'd13) ? hi : 3'h7, lo};
        m = w[7:0]; t = w[15:8];
      end
      5'd15, 5'd16, 5'd17: begin
        r = a ^ ((o == 5'd17) ? i : m);
        f[2] = (r == 8'h00);
        if (o == 5'd16) m = r; else a = r;
      end
      default: ;
    endcase
    return {k, t, f, m, a};
  endfunction : expect_of
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  // ------------------------------------------------------------
  // main sequence: reset, corner cases, then random instructions
  // ------------------------------------------------------------
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, wdata, araddr} = {32'h0, 32'h0, 32'h0};
    failures = 0; cmp_count = 0; sk_cnt = 0; tb = 8'h00; ws = 4'hf;
    void'($urandom(73485));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFS_ACC); chk("acc reset", rd_d, 32'h0000_0000);
    rd(OFS_FLAGS); chk("flags reset", rd_d, 32'h0000_0000);
    rd(8'h40); chk("unmapped read", {rd_d[29:0], rd_r}, {30'h0, RESP_SLVERR});
    wr(8'h40, 32'h0000_00ff); chk("unmapped write", wr_r, RESP_SLVERR);
    // a write with lane 0 masked off must leave the register alone
    ws <= 4'h0; wr(OFS_ACC, 32'h0000_00a5); ws <= 4'hf;
    rd(OFS_ACC); chk("masked write", rd_d, 32'h0000_0000);
    for (n = 0; n < 120; n++) begin
      // first two rounds walk every opcode with edge operands
      // codes 18 and 19 are unused and must act as no-ops
      op = (n < 36) ? 5'(n % 18) : 5'($urandom_range(19, 0));
      m = (n < 18) ? 8'hff : (n < 36) ? 8'h00 : 8'($urandom);
      a = (n < 36) ? 8'h7f : 8'($urandom);
      i = (n < 36) ? m : 8'($urandom);
      {adr, b, lo, hi, f} = 24'($urandom);
      wr(OFS_MADDR, {26'h0, adr}); wr(OFS_MDATA, {24'h0, m});
      wr(OFS_ACC, {24'h0, a}); wr(OFS_FLAGS, {28'h0, f});
      wr(OFS_TIL, {24'h0, lo}); wr(OFS_TIH, {29'h0, hi});
      ex = expect_of(op, a, m, i, lo, tb, b, hi, f);
      sk_cnt = 0;
      wr(OFS_CMD, {8'h00, i, 2'b00, adr, b, op});
      for (int k = 0; k < 50 && busy !== 1'b0; k++) @(posedge aclk);
      rd(OFS_ACC); chk("acc", rd_d, {24'h0, ex[7:0]});
      rd(OFS_MDATA); chk("mem", rd_d, {24'h0, ex[15:8]});
      rd(OFS_FLAGS); chk("flags", rd_d, {28'h0, ex[19:16]});
      rd(OFS_TUB); chk("upper byte", rd_d, {24'h0, ex[27:20]});
      rd(OFS_STATUS);
      chk("status", rd_d, {28'h0, (ex[28] || op == 5'd13 || op == 5'd14)
          ? CYC_SKIP : CYC_PLAIN, ex[28], 1'b0});
      chk("skip pulses", 32'(sk_cnt), {31'h0, ex[28]});
      tb = ex[27:20];
    end
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
